// *** common/smc_fifo_if.sv ***
interface smc_fifo_if #(
  parameter int WIDTH = 8
);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;

  modport fifo (
    input  in_valid,
    input  in_data,
    input  out_ready,
    output in_ready,
    output out_valid,
    output out_data
  );

  modport user (
    output in_valid,
    output in_data,
    output out_ready,
    input  in_ready,
    input  out_valid,
    input  out_data
  );
endinterface : smc_fifo_if

// *** common/smc_pkg.sv ***
package smc_pkg;

  // Data path widths and write queue depth
  localparam int BYTE_W     = 8;
  localparam int TXQ_DEPTH  = 16;
  localparam int RATE_W     = 3;
  localparam int EDGE_W     = 4;
  localparam int DIV_W      = 8;

  // Sixteen clock edges make eight full clock cycles per byte
  localparam logic [EDGE_W-1:0] EDGE_LAST      = 4'hf;
  // Highest usable rate code; code 3'h7 is reserved and behaves as 3'h6
  localparam logic [RATE_W-1:0] RATE_MAX_CODE  = 3'h6;
  // Half period of the fastest rate; also the divider's step and the base of its bound
  localparam logic [DIV_W-1:0]  HALF_ONE       = 8'h01;

  // Byte sent first when acting as source of the flow channel
  localparam logic [BYTE_W-1:0] DUMMY_BYTE     = 8'hff;

  // Reset values
  localparam logic [BYTE_W-1:0] BYTE_RST       = 8'h00;
  localparam logic [EDGE_W-1:0] EDGE_RST       = 4'h0;
  localparam logic [DIV_W-1:0]  DIV_RST        = 8'h00;
  localparam logic              SCK_RST        = 1'b1;

  // Controller state, one-hot
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_MASTER = 3'b010,
    ST_SLAVE  = 3'b100
  } smc_state_t;

endpackage : smc_pkg

// *** core/smc_fifo.sv ***
module smc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  smc_fifo_if.fifo f
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = PTR_W + 1;
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic [WIDTH-1:0] out_data_reg;
  logic             out_valid_reg;
  logic             in_ready_reg;
  logic             push;
  logic             pop;

  assign push       = f.in_valid && in_ready_reg;
  // Refill the output register whenever it is empty or being drained
  assign pop        = (count_reg != '0) && (!out_valid_reg || f.out_ready);
  assign count_next = count_reg + CNT_W'(push) - CNT_W'(pop);

  assign f.in_ready  = in_ready_reg;
  assign f.out_valid = out_valid_reg;
  assign f.out_data  = out_data_reg;

  // Storage write side
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= f.in_data;
    end
  end

  // Pointers and fill level; ready is registered so it never lies
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg   <= '0;
      rd_ptr_reg   <= '0;
      count_reg    <= '0;
      in_ready_reg <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg    <= count_next;
      in_ready_reg <= (count_next != FULL_CNT);
    end
  end

  // Registered read data
  always_ff @(posedge clk) begin
    if (rst) begin
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
    end else if (pop) begin
      out_valid_reg <= 1'b1;
      out_data_reg  <= mem[rd_ptr_reg];
    end else if (f.out_ready) begin
      out_valid_reg <= 1'b0;
    end
  end

  a_fifo_no_overflow: assert property (@(posedge clk) disable iff (rst)
    count_reg <= FULL_CNT)
    else $error("fifo level above depth");

endmodule : smc_fifo

// *** core/smc_spi_ctrl.sv ***
// Summary of operation
// (RULE1) Master sends eight SCK cycles per byte, one byte each way.
// (RULE2) MOSI driven only by master, MISO only by selected slave.
// (RULE3) With master_select set, generate SCK and drive MOSI.
// (RULE4) Only master mode starts a transfer; slave never self-starts.
// (RULE5) Written byte goes to holding buffer, moved to shifter when idle.
// (RULE6) Reads return receive buffer, refreshed at end of each transfer.
// (RULE7) Bit order MSB first, or LSB first when lsb_first_select set.
// (RULE8) transfer_done_flag set at end of every byte, either mode.
// (RULE9) As flow source, send FFh first, then echo last received byte.
// (RULE10) Flow channel serves one direction only at a time.
// (RULE11) select_pin_disable frees select pin; no effect in slave with phase clear.
// (RULE12) Slave role when master_select clear and byte loaded.
// (RULE13) External master holds select low across whole byte.
// (RULE14) Slave shifts MOSI in and shifter out on MISO on master's SCK.
// (RULE15) Rate codes 0..6 divide clock by 2..128; code 7 reserved.
// (RULE16) External SCK must stay at or below a quarter of oscillator.
// (RULE17) Clock polarity sets SCK idle level.
// (RULE18) Clock phase picks sampling edges and shifting edges.
// (RULE19) SCK rests high while controller disabled.
// (RULE20) Software picks mode before enabling; master configured first.
// (RULE21) Flag cleared by status read with flag set, then data access.
// (RULE22) Select high releases MISO, clears bit count, ignores SCK.
// (RULE23) Byte arriving before previous one read sets overrun, is dropped.
// (RULE24) Slave SCK and select synchronised before edges are used.
// (RULE25) LSB-first order applied alike to sent and received bytes.
module smc_spi_ctrl
  import smc_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire logic              CONTROLLER_ENABLE,
  input  wire logic              MASTER_SELECT,
  input  wire logic              SELECT_PIN_DISABLE,
  input  wire logic              LSB_FIRST_SELECT,
  input  wire logic              CLOCK_IDLE_POLARITY,
  input  wire logic              CLOCK_EDGE_PHASE,
  input  wire logic [RATE_W-1:0] RATE_SEL,
  input  wire logic              FLOW_CHAN_EN,
  input  wire logic              FLOW_CHAN_SOURCE,
  input  wire logic              DH_WR,
  input  wire logic [BYTE_W-1:0] DH_WDATA,
  output wire logic              DH_WR_READY,
  input  wire logic              DH_RD,
  output wire logic [BYTE_W-1:0] DH_RDATA,
  input  wire logic              STATUS_RD,
  output wire logic              TRANSFER_DONE_FLAG,
  output wire logic              OVERRUN_FLAG,
  output wire logic              SS_PIN_RELEASED,
  input  wire logic              SCK_I,
  output wire logic              SCK_O,
  output wire logic              SCK_OE,
  input  wire logic              MOSI_I,
  output wire logic              MOSI_O,
  output wire logic              MOSI_OE,
  input  wire logic              MISO_I,
  output wire logic              MISO_O,
  output wire logic              MISO_OE,
  input  wire logic              SS_N_I
);

  // Shift one bit in; direction follows the bit order
  function automatic logic [BYTE_W-1:0] shift_in(input logic [BYTE_W-1:0] sh,
                                                input logic bit_in,
                                                input logic lsb);
    shift_in = lsb ? {bit_in, sh[BYTE_W-1:1]} : {sh[BYTE_W-2:0], bit_in};
  endfunction : shift_in

  // Bit presented on the data line for the current shifter content
  function automatic logic out_bit(input logic [BYTE_W-1:0] sh, input logic lsb);
    out_bit = lsb ? sh[0] : sh[BYTE_W-1];
  endfunction : out_bit

  smc_state_t        state_reg;
  smc_state_t        state_next;
  logic [DIV_W-1:0]  div_cnt_reg;
  logic [DIV_W-1:0]  half_w;
  logic [EDGE_W-1:0] edge_cnt_reg;
  logic [BYTE_W-1:0] sh_reg;
  logic [BYTE_W-1:0] sh_in_w;
  logic [BYTE_W-1:0] tx_buf_reg;
  logic              tx_full_reg;
  logic [BYTE_W-1:0] rx_buf_reg;
  logic              rx_full_reg;
  logic              out_reg;
  logic              sck_reg;
  logic              sck_oe_reg;
  logic              mosi_oe_reg;
  logic              miso_oe_reg;
  logic              done_flag_reg;
  logic              ovr_flag_reg;
  logic              status_seen_reg;
  logic              primed_reg;
  logic              ss_rel_reg;
  logic              sck_s1_reg;
  logic              sck_s2_reg;
  logic              sck_s3_reg;
  logic              ss_s1_reg;
  logic              ss_s2_reg;
  logic              mosi_s1_reg;
  logic              mosi_s2_reg;
  logic              master_on;
  logic              slave_on;
  logic              sel_w;
  logic              m_tick;
  logic              s_edge;
  logic              edge_ev;
  logic              sample_ev;
  logic              in_bit;
  logic              done_w;
  logic              flow_src;
  logic              start_buf;
  logic              start_dummy;
  logic              start_echo;
  logic              start_m;
  logic              slave_load;
  logic              rx_free;
  logic              clear_seq;

  smc_fifo_if #(.WIDTH(BYTE_W)) txq ();

  // Write queue ahead of the holding buffer; stalls while buffer is full
  smc_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (TXQ_DEPTH)
  ) u_txq (
    .clk (CLK),
    .rst (RST),
    .f   (txq.fifo)
  );

  assign txq.in_valid  = DH_WR;
  assign txq.in_data   = DH_WDATA;
  assign txq.out_ready = !tx_full_reg;
  assign DH_WR_READY   = txq.in_ready;

  // Synchronisers for the slave side inputs
  always_ff @(posedge CLK) begin
    if (RST) begin
      sck_s1_reg  <= SCK_RST;
      sck_s2_reg  <= SCK_RST;
      sck_s3_reg  <= SCK_RST;
      ss_s1_reg   <= 1'b1;
      ss_s2_reg   <= 1'b1;
      mosi_s1_reg <= 1'b0;
      mosi_s2_reg <= 1'b0;
    end else begin
      sck_s1_reg  <= SCK_I; // RULE24
      sck_s2_reg  <= sck_s1_reg;
      sck_s3_reg  <= sck_s2_reg;
      ss_s1_reg   <= SS_N_I; // RULE24
      ss_s2_reg   <= ss_s1_reg;
      mosi_s1_reg <= MOSI_I;
      mosi_s2_reg <= mosi_s1_reg;
    end
  end

  // Mode decode and edge events
  assign master_on = CONTROLLER_ENABLE && MASTER_SELECT; // RULE3
  assign slave_on  = CONTROLLER_ENABLE && !MASTER_SELECT; // RULE12
  // Disabling the pin keeps the slave selected, but not in phase-0 format
  assign sel_w     = !ss_s2_reg || (SELECT_PIN_DISABLE && CLOCK_EDGE_PHASE); // RULE11
  assign half_w    = HALF_ONE << ((RATE_SEL > RATE_MAX_CODE) ? RATE_MAX_CODE : RATE_SEL); // RULE15
  // Compare with >= so that a rate lowered mid-byte cannot strand the divider
  assign m_tick    = (state_reg == ST_MASTER) && (div_cnt_reg >= half_w - HALF_ONE);
  assign s_edge    = (state_reg == ST_SLAVE) && sel_w && (sck_s2_reg != sck_s3_reg); // RULE14
  assign edge_ev   = m_tick || s_edge;
  // Phase 0 samples on even edges, phase 1 on odd edges
  assign sample_ev = edge_ev && (edge_cnt_reg[0] == CLOCK_EDGE_PHASE); // RULE18
  assign in_bit    = (state_reg == ST_MASTER) ? MISO_I : mosi_s2_reg;
  assign sh_in_w   = shift_in(sh_reg, in_bit, LSB_FIRST_SELECT); // RULE7 RULE25
  assign done_w    = edge_ev && (edge_cnt_reg == EDGE_LAST); // RULE1

  // A single direction bit means the channel can never serve both flows
  assign flow_src    = FLOW_CHAN_EN && FLOW_CHAN_SOURCE; // RULE10
  assign start_buf   = (state_reg == ST_IDLE) && master_on && tx_full_reg; // RULE5
  assign start_dummy = (state_reg == ST_IDLE) && master_on && !tx_full_reg
                       && flow_src && !primed_reg; // RULE9
  assign start_echo  = (state_reg == ST_IDLE) && master_on && !tx_full_reg
                       && flow_src && primed_reg && !rx_full_reg; // RULE9
  assign start_m     = start_buf || start_dummy || start_echo; // RULE4
  assign slave_load  = (state_reg == ST_SLAVE) && (edge_cnt_reg == EDGE_RST)
                       && !edge_ev && tx_full_reg; // RULE5 RULE12
  assign rx_free     = !rx_full_reg || DH_RD;
  assign clear_seq   = status_seen_reg && (DH_RD || DH_WR);

  // Next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (slave_on) begin
          state_next = ST_SLAVE;
        end else if (start_m) begin
          state_next = ST_MASTER;
        end
      end
      ST_MASTER: begin
        // Dropping master mode aborts the byte
        if (!master_on || done_w) begin
          state_next = ST_IDLE;
        end
      end
      ST_SLAVE: begin
        if (!slave_on) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Bit rate divider, counts half periods of SCK
  always_ff @(posedge CLK) begin
    if (RST || state_reg != ST_MASTER || m_tick) begin
      div_cnt_reg <= DIV_RST;
    end else begin
      div_cnt_reg <= div_cnt_reg + HALF_ONE;
    end
  end

  // Edge counter; deselect wipes it mid-byte
  always_ff @(posedge CLK) begin
    if (RST || state_reg == ST_IDLE) begin
      edge_cnt_reg <= EDGE_RST;
    end else if (slave_on && !sel_w) begin
      edge_cnt_reg <= EDGE_RST; // RULE22
    end else if (edge_ev) begin
      edge_cnt_reg <= edge_cnt_reg + 4'h1;
    end
  end

  // Shifter; left alone after a byte so it echoes the last byte received
  always_ff @(posedge CLK) begin
    if (RST) begin
      sh_reg <= BYTE_RST;
    end else if (start_dummy) begin
      sh_reg <= DUMMY_BYTE; // RULE9
    end else if (start_buf || slave_load) begin
      sh_reg <= tx_buf_reg; // RULE5
    end else if (sample_ev) begin
      sh_reg <= sh_in_w; // RULE14
    end
  end

  // Data line bit, shared by MOSI and MISO
  always_ff @(posedge CLK) begin
    if (RST) begin
      out_reg <= 1'b0;
    end else if (start_dummy) begin
      out_reg <= out_bit(DUMMY_BYTE, LSB_FIRST_SELECT);
    end else if (start_buf || slave_load) begin
      out_reg <= out_bit(tx_buf_reg, LSB_FIRST_SELECT); // RULE7
    end else if (start_echo) begin
      out_reg <= out_bit(sh_reg, LSB_FIRST_SELECT);
    end else if (edge_ev && !sample_ev) begin
      out_reg <= out_bit(sh_reg, LSB_FIRST_SELECT); // RULE18
    end else if (state_reg == ST_SLAVE && edge_cnt_reg == EDGE_RST) begin
      out_reg <= out_bit(sh_reg, LSB_FIRST_SELECT);
    end
  end

  // Serial clock level
  always_ff @(posedge CLK) begin
    if (RST || !CONTROLLER_ENABLE) begin
      sck_reg <= SCK_RST; // RULE19
    end else if (state_reg != ST_MASTER) begin
      sck_reg <= CLOCK_IDLE_POLARITY; // RULE17
    end else if (m_tick) begin
      sck_reg <= !sck_reg; // RULE1
    end
  end

  // Pin drive enables and select pin release
  always_ff @(posedge CLK) begin
    if (RST) begin
      sck_oe_reg  <= 1'b0;
      mosi_oe_reg <= 1'b0;
      miso_oe_reg <= 1'b0;
      ss_rel_reg  <= 1'b0;
    end else begin
      sck_oe_reg  <= master_on; // RULE3
      mosi_oe_reg <= master_on; // RULE2
      miso_oe_reg <= slave_on && sel_w; // RULE2 RULE22
      ss_rel_reg  <= CONTROLLER_ENABLE && SELECT_PIN_DISABLE
                     && (MASTER_SELECT || CLOCK_EDGE_PHASE); // RULE11
    end
  end

  // Holding buffer between write queue and shifter
  always_ff @(posedge CLK) begin
    if (RST) begin
      tx_buf_reg  <= BYTE_RST;
      tx_full_reg <= 1'b0;
    end else if (txq.out_valid && !tx_full_reg) begin
      tx_buf_reg  <= txq.out_data; // RULE5
      tx_full_reg <= 1'b1;
    end else if (start_buf || slave_load) begin
      tx_full_reg <= 1'b0;
    end
  end

  // Receive buffer; an unread byte is kept and the newcomer dropped
  always_ff @(posedge CLK) begin
    if (RST) begin
      rx_buf_reg  <= BYTE_RST;
      rx_full_reg <= 1'b0;
    end else if (done_w && rx_free) begin
      rx_buf_reg  <= sample_ev ? sh_in_w : sh_reg; // RULE6 RULE25
      rx_full_reg <= 1'b1;
    end else if (DH_RD) begin
      rx_full_reg <= 1'b0;
    end
  end

  // Status flags; a new event beats a clear in the same cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      done_flag_reg   <= 1'b0;
      ovr_flag_reg    <= 1'b0;
      status_seen_reg <= 1'b0;
    end else begin
      if (done_w) begin
        done_flag_reg <= 1'b1; // RULE8
      end else if (clear_seq) begin
        done_flag_reg <= 1'b0; // RULE21
      end
      if (done_w && !rx_free) begin
        ovr_flag_reg <= 1'b1; // RULE23
      end else if (clear_seq) begin
        ovr_flag_reg <= 1'b0;
      end
      if (clear_seq) begin
        status_seen_reg <= 1'b0;
      end else if (STATUS_RD && done_flag_reg) begin
        status_seen_reg <= 1'b1; // RULE21
      end
    end
  end

  // Dummy byte goes out once per flow session
  always_ff @(posedge CLK) begin
    if (RST || !flow_src) begin
      primed_reg <= 1'b0;
    end else if (start_dummy) begin
      primed_reg <= 1'b1; // RULE9
    end
  end

  assign DH_RDATA           = rx_buf_reg;
  assign TRANSFER_DONE_FLAG = done_flag_reg;
  assign OVERRUN_FLAG       = ovr_flag_reg;
  assign SS_PIN_RELEASED    = ss_rel_reg;
  assign SCK_O              = sck_reg;
  assign SCK_OE             = sck_oe_reg;
  assign MOSI_O             = out_reg;
  assign MOSI_OE            = mosi_oe_reg;
  assign MISO_O             = out_reg;
  assign MISO_OE            = miso_oe_reg;

  a_sck_rest_high: assert property (@(posedge CLK) disable iff (RST) // RULE19
    !CONTROLLER_ENABLE |=> SCK_O)
    else $error("SCK not high while disabled");

  a_slave_no_start: assert property (@(posedge CLK) disable iff (RST) // RULE4
    !MASTER_SELECT |=> state_reg != ST_MASTER)
    else $error("transfer started outside master mode");

  a_master_drives: assert property (@(posedge CLK) disable iff (RST) // RULE3
    master_on |=> (SCK_OE && MOSI_OE && !MISO_OE))
    else $error("master not driving SCK and MOSI");

  a_miso_release: assert property (@(posedge CLK) disable iff (RST) // RULE22
    (slave_on && !sel_w) |=> (!MISO_OE && edge_cnt_reg == EDGE_RST))
    else $error("deselected slave still active");

  a_done_sets_flag: assert property (@(posedge CLK) disable iff (RST) // RULE8
    done_w |=> TRANSFER_DONE_FLAG)
    else $error("done flag not set after byte");

  a_overrun_keep: assert property (@(posedge CLK) disable iff (RST) // RULE23
    (done_w && rx_full_reg && !DH_RD) |=>
      (OVERRUN_FLAG && DH_RDATA == $past(DH_RDATA)))
    else $error("unread byte overwritten");

  a_buffer_start: assert property (@(posedge CLK) disable iff (RST) // RULE5
    start_buf |=> (state_reg == ST_MASTER && sh_reg == $past(tx_buf_reg)))
    else $error("holding buffer not loaded at start");

  a_rate_bound: assert property (@(posedge CLK) disable iff (RST) // RULE15
    (state_reg == ST_MASTER && RATE_SEL == 3'h0 && $stable(RATE_SEL))
      |-> m_tick)
    else $error("divide by two not ticking every cycle");

  a_idle_polarity: assert property (@(posedge CLK) disable iff (RST) // RULE17
    (CONTROLLER_ENABLE && state_reg == ST_IDLE) |=> SCK_O == $past(CLOCK_IDLE_POLARITY))
    else $error("SCK idle level wrong");

  a_rx_update: assert property (@(posedge CLK) disable iff (RST) // RULE6
    (done_w && !rx_full_reg) |=> (DH_RDATA == $past(sample_ev ? sh_in_w : sh_reg)))
    else $error("receive buffer not updated");

endmodule : smc_spi_ctrl

// *** test/smc_slave_model.sv ***
module smc_slave_model (
  input  wire logic       sck,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  input  wire logic       clock_idle_polarity,
  input  wire logic       clock_edge_phase,
  input  wire logic       lsb,
  input  wire logic [7:0] tx_byte,
  output wire logic       miso,
  output logic      [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] txs = 8'h00;
  logic [7:0] rxs = 8'h00;
  logic       last = 1'b0;
  int         cnt = 0;

  // Released line shows the inverse of the last bit, never a held value
  assign miso = ss_n ? ~last : last;

  // Present next outgoing bit in the chosen order
  task automatic put();
    last = lsb ? txs[0] : txs[7];
    txs  = lsb ? txs >> 1 : txs << 1;
  endtask : put

  // Load on select; with phase clear the first bit goes out at once
  always @(negedge ss_n) begin
    txs = tx_byte;
    cnt = 0;
    if (!clock_edge_phase) put();
  end

  // Leading edge samples when phase clear, trailing edge when set
  always @(sck) begin
    if (!ss_n) begin
      if ((sck !== clock_idle_polarity) != clock_edge_phase) begin
        rxs = lsb ? {mosi, rxs[7:1]} : {rxs[6:0], mosi};
        cnt++;
        if (cnt == 8) begin
          rx_byte = rxs;
          cnt     = 0;
          txs     = tx_byte;
        end
      end else begin
        put();
      end
    end
  end
endmodule : smc_slave_model

// *** test/testbench.sv ***
module testbench
  import smc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, en = 1'b0, mst = 1'b0, ssd = 1'b0;
  logic        lsb = 1'b0, clock_idle_polarity = 1'b0, clock_edge_phase = 1'b0, fen = 1'b0, fsrc = 1'b0;
  logic        wr = 1'b0, rd = 1'b0, srd = 1'b0, tb_sck = 1'b0, tb_mosi = 1'b0;
  logic        ss_n = 1'b1, m_ss_n = 1'b1, mon = 1'b0, sck_q = 1'b1;
  logic [2:0]  rate = 3'h0;
  logic [7:0]  wdata = 8'h00, m_tx = 8'h00, m_rx, rdata;
  logic        wr_rdy, done, overrun_flag, ssrel, sck_o, sck_oe, mosi_o, mosi_oe;
  logic        miso_o, miso_oe, m_miso;
  int          num_errors = 0, n_tests = 0, cyc = 0, edges = 0, gap = 0, exp_gap = 1, bi = 0;
  // Wire levels picked by the DUT's enables; bench and partner drive otherwise
  wire         sck_w  = sck_oe ? sck_o : tb_sck;
  wire         mosi_w = mosi_oe ? mosi_o : tb_mosi;
  wire         miso_w = miso_oe ? miso_o : m_miso;

  always #5 clk = ~clk;

  smc_spi_ctrl DUT (
    .CLK(clk), .RST(rst), .CONTROLLER_ENABLE(en), .MASTER_SELECT(mst),
    .SELECT_PIN_DISABLE(ssd), .LSB_FIRST_SELECT(lsb), .CLOCK_IDLE_POLARITY(clock_idle_polarity),
    .CLOCK_EDGE_PHASE(clock_edge_phase), .RATE_SEL(rate), .FLOW_CHAN_EN(fen), .FLOW_CHAN_SOURCE(fsrc),
    .DH_WR(wr), .DH_WDATA(wdata), .DH_WR_READY(wr_rdy), .DH_RD(rd), .DH_RDATA(rdata),
    .STATUS_RD(srd), .TRANSFER_DONE_FLAG(done), .OVERRUN_FLAG(overrun_flag),
    .SS_PIN_RELEASED(ssrel), .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE(sck_oe),
    .MOSI_I(mosi_w), .MOSI_O(mosi_o), .MOSI_OE(mosi_oe), .MISO_I(miso_w),
    .MISO_O(miso_o), .MISO_OE(miso_oe), .SS_N_I(ss_n)
  );

  smc_slave_model PARTNER (
    .sck(sck_w), .ss_n(m_ss_n), .mosi(mosi_w), .clock_idle_polarity(clock_idle_polarity), .clock_edge_phase(clock_edge_phase), .lsb(lsb),
    .tx_byte(m_tx), .miso(m_miso), .rx_byte(m_rx)
  );

  // Hang guard well above the few thousand cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      complete_run();
    end
  end

  // Edge count and spacing of the generated clock; first edge of a byte skipped
  always @(posedge clk) begin
    sck_q <= sck_o;
    gap   <= gap + 1;
    if (sck_oe && sck_q !== sck_o) begin
      edges <= edges + 1;
      gap   <= 1;
      if (mon && bi != 0) chk_byte("sck gap", 8'(exp_gap), 8'(gap));
      bi    <= (!mon || bi == 15) ? 0 : bi + 1;
    end
  end

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_byte

  // Back-to-back writes keep the strobe high across the bytes
  task automatic dh_write(input logic [7:0] d[$]);
    chk_bit("write ready", 1'b1, wr_rdy);
    foreach (d[i]) begin
      wr    <= 1'b1;
      wdata <= d[i];
      @(posedge clk);
    end
    wr <= 1'b0;
  endtask : dh_write

  // Bounded wait on the done flag, or on overrun when sel is set
  task automatic wait_flag(input logic sel);
    for (int i = 0; i < 3000 && (sel ? overrun_flag : done) !== 1'b1; i++) @(posedge clk);
    chk_bit(sel ? "overrun flag" : "done flag", 1'b1, sel ? overrun_flag : done);
    repeat (2) @(posedge clk);
  endtask : wait_flag

  // Status read with flag set, then a data read
  task automatic clear_flags();
    srd <= 1'b1;
    @(posedge clk);
    srd <= 1'b0;
    rd  <= 1'b1;
    @(posedge clk);
    rd  <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : clear_flags

  // Mode chosen while disabled, then enabled
  task automatic setup(input int k);
    en <= 1'b0;
    repeat (3) @(posedge clk);
    chk_bit("sck while disabled", 1'b1, sck_o);
    mst               <= 1'b1;
    ssd               <= (k == 5);
    {lsb, clock_edge_phase, clock_idle_polarity} <= 3'(k);
    rate              <= 3'(k);
    exp_gap           = 1 << ((k > 6) ? 6 : k);
    @(posedge clk);
    en <= 1'b1;
    repeat (3) @(posedge clk);
    chk_bit("sck idle level", clock_idle_polarity, sck_o);
    chk_bit("sck driven", 1'b1, sck_oe);
    chk_bit("select pin free", k == 5, ssrel);
  endtask : setup

  task automatic master_xfer(input int k, input logic [7:0] d[$], input logic [7:0] s1,
                             input logic [7:0] s2);
    int e0;
    m_tx   <= s1;
    setup(k);
    m_ss_n <= 1'b0;
    @(posedge clk);
    m_tx <= s2;
    e0   = edges;
    mon  <= 1'b1;
    dh_write(d);
    wait_flag(1'b0);
    if (d.size() > 1) wait_flag(1'b1);
    mon <= 1'b0;
    chk_byte("sck edges", 8'(16 * d.size()), 8'(edges - e0));
    chk_byte("received byte", s1, rdata);
    chk_byte("sent byte", d[d.size() - 1], m_rx);
    chk_bit("sck rest", clock_idle_polarity, sck_o);
    clear_flags();
    chk_bit("done cleared", 1'b0, done);
    chk_bit("overrun cleared", 1'b0, overrun_flag);
    m_ss_n <= 1'b1;
  endtask : master_xfer

  // Bench acts as external master, half period 8 cycles, well under the limit
  task automatic slave_xfer(input logic [7:0] mv, input logic [7:0] sv);
    logic [7:0] got;
    en <= 1'b0;
    {mst, ssd, clock_edge_phase} <= 3'b010;
    @(posedge clk);
    en <= 1'b1;
    repeat (3) @(posedge clk);
    chk_bit("select pin kept", 1'b0, ssrel);
    {ssd, clock_edge_phase} <= 2'b01;
    @(posedge clk);
    dh_write('{sv});
    repeat (40) @(posedge clk);
    chk_bit("slave sck drive", 1'b0, sck_oe);
    chk_bit("slave self start", 1'b0, done);
    ss_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 7; i >= 0; i--) begin
      tb_sck  <= 1'b1;
      tb_mosi <= mv[i];
      repeat (8) @(posedge clk);
      got[i] = miso_w;
      tb_sck <= 1'b0;
      repeat (8) @(posedge clk);
    end
    chk_bit("miso driven", 1'b1, miso_oe);
    wait_flag(1'b0);
    chk_byte("slave sent", sv, got);
    chk_byte("slave received", mv, rdata);
    ss_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk_bit("miso released", 1'b0, miso_oe);
  endtask : slave_xfer

  task automatic complete_run();
    if (num_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk_bit("sck after reset", 1'b1, sck_o);
    chk_byte("rdata after reset", 8'h00, rdata);
    for (int k = 0; k < 8; k++) begin
      master_xfer(k, '{8'(8'hb1 ^ (k << 4))}, 8'(8'h6a + k * 19), 8'h00);
    end
    master_xfer(2, '{8'h81, 8'h42}, 8'h99, 8'h24);
    // Flow source: dummy byte first, then echo of the last byte received
    m_tx   <= 8'h3c;
    setup(2);
    m_ss_n <= 1'b0;
    fen    <= 1'b1;
    fsrc   <= 1'b1;
    wait_flag(1'b0);
    chk_byte("flow dummy", DUMMY_BYTE, m_rx);
    clear_flags();
    wait_flag(1'b0);
    fen <= 1'b0;
    chk_byte("flow echo", 8'h3c, m_rx);
    clear_flags();
    m_ss_n <= 1'b1;
    slave_xfer(8'h6e, 8'hc5);
    complete_run();
  end
endmodule : testbench
